// ---- src/ntbws_cfg.svh ----
`ifndef NTBWS_CFG_SVH
`define NTBWS_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define NTBWS_OFS_DS_SETUP    8'h14
`define NTBWS_OFS_DS_UPPER    8'h18
`define NTBWS_OFS_US_SETUP    8'h34
`define NTBWS_OFS_US_UPPER    8'h38
`define NTBWS_OFS_PTR         8'h50
`define NTBWS_OFS_LUT_DATA    8'h54

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define NTBWS_TYPE_BIT        0
`define NTBWS_WIDTH_HI        2
`define NTBWS_WIDTH_LO        1
`define NTBWS_PF_BIT          3
`define NTBWS_RSV_HI          11
`define NTBWS_RSV_LO          4
`define NTBWS_DS_MASK_HI      30
`define NTBWS_US_MASK_HI      31
`define NTBWS_MASK_LO         12
`define NTBWS_EN_BIT          31
`define NTBWS_PTR_HI          7
`define NTBWS_LUT_IDX_HI      7
`define NTBWS_LUT_IDX_LO      2

// ----------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------
`define NTBWS_WIDTH_32        2'h0
`define NTBWS_WIDTH_64        2'h1
`define NTBWS_RST_DS_SETUP    32'h0000_0000
`define NTBWS_RST_UPPER       32'h0000_0000
`define NTBWS_RST_US_PF       1'h0
`define NTBWS_RST_US_MASK     20'h0_0000
`define NTBWS_RST_PTR         8'h00
`define NTBWS_RST_LUT         32'h0000_0000
`define NTBWS_LUT_WMASK       32'hffff_ff09
`define NTBWS_LUT_DEPTH       64

`endif

// ---- src/ntbws_pkg.sv ----
package ntbws_pkg;
  typedef logic [31:0] ntbws_word_t;
  typedef logic [7:0]  ntbws_addr_t;
  typedef logic [5:0]  ntbws_lut_idx_t;
endpackage : ntbws_pkg

// ---- src/ntbws_lut.sv ----
`timescale 1ns/1ns
`include "ntbws_cfg.svh"

module ntbws_lut
  import ntbws_pkg::*;
(
  // Clock and reset
  input  wire logic           i_ref_clk,
  input  wire logic           i_rst,
  // Entry access
  input  wire logic           i_wr,
  input  wire ntbws_lut_idx_t i_idx,
  input  wire ntbws_word_t    i_wdata,
  output ntbws_word_t         o_rdata
);

  ntbws_word_t mem_reg [`NTBWS_LUT_DEPTH];

  // ----------------------------------------------------------------
  // Entry storage
  // ----------------------------------------------------------------
  // Reserved bits are never stored, so they always read back as zero.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < `NTBWS_LUT_DEPTH; i++) begin
        mem_reg[i] <= `NTBWS_RST_LUT;
      end
    end else if (i_wr) begin
      mem_reg[i_idx] <= i_wdata & `NTBWS_LUT_WMASK;
    end
  end

  assign o_rdata = mem_reg[i_idx];

  a_lut_rsv_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (o_rdata & ~`NTBWS_LUT_WMASK) == 32'h0000_0000)
    else $error("lookup entry reserved bits not zero");

endmodule : ntbws_lut

// ---- src/ntbws_regs.sv ----
`timescale 1ns/1ns
`include "ntbws_cfg.svh"

// Notes on behaviour
// R1 - Setup bit 0 reads zero, memory space.
// R2 - Width field 00 means 32-bit, 01 64-bit.
// R3 - Bit 3 marks window prefetchable when set.
// R4 - Downstream mask bits gate base bit writability.
// R5 - Downstream enable bit 31 resets to off.
// R6 - Upper mask gates upper base bits, resets zero.
// R7 - Upper bit 31 writable, enables 64-bit base.
// R8 - Upstream width field read-only, resets to 01.
// R9 - Upstream prefetch and mask writable; 11:4 zero.
// R10 - Pointer holds entry byte offset; upper bits zero.
// R11 - Table entry touched only by data register access.
// R12 - Software writes pointer before data access.
// R13 - Data register writes and reads selected entry.
// R14 - Disabled window claims nothing, base reads zero.

module ntbws_regs
  import ntbws_pkg::*;
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // Register access port
  input  wire logic        i_csr_wr,
  input  wire logic        i_csr_rd,
  input  wire ntbws_addr_t i_csr_addr,
  input  wire ntbws_word_t i_csr_wdata,
  output ntbws_word_t      o_csr_rdata,
  output logic             o_csr_ack,
  // Initial load of read-only setup fields
  input  wire logic        i_init_load_writable,
  input  wire ntbws_word_t i_init_data,
  // Downstream window to address decode
  output logic             o_ds_claim_en,
  output logic             o_ds_prefetch,
  output logic [1:0]       o_ds_width,
  output ntbws_word_t      o_ds_base_rw_mask,
  output logic             o_ds_upper_claim_en,
  output ntbws_word_t      o_ds_upper_rw_mask,
  // Upstream window to address decode
  output logic             o_us_prefetch,
  output ntbws_word_t      o_us_base_rw_mask,
  output logic             o_us_upper_claim_en,
  output ntbws_word_t      o_us_upper_rw_mask
);

  ntbws_word_t ds_setup_reg;
  ntbws_word_t ds_upper_reg;
  ntbws_word_t us_upper_reg;
  logic        us_pf_reg;
  logic [19:0] us_mask_reg;
  logic [7:0]  ptr_reg;
  ntbws_word_t lut_rdata;
  ntbws_word_t rdata_next;
  logic        lut_wr;

  // ----------------------------------------------------------------
  // Downstream setup
  // ----------------------------------------------------------------
  // Software cannot change this word; only the initial load may.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ds_setup_reg <= `NTBWS_RST_DS_SETUP; // [R5]
    end else if (i_init_load_writable) begin
      // Reserved bits 11:4 are dropped here so they can never read back non-zero.
      ds_setup_reg <= {i_init_data[31:12], 8'h00, i_init_data[3:1], 1'b0}; // [R2] [R3] [R4]
    end
  end

  // ----------------------------------------------------------------
  // Upper setup words
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ds_upper_reg <= `NTBWS_RST_UPPER; // [R6]
      us_upper_reg <= `NTBWS_RST_UPPER;
    end else if (i_csr_wr) begin
      if (i_csr_addr == `NTBWS_OFS_DS_UPPER) begin
        ds_upper_reg <= i_csr_wdata; // [R6] [R7]
      end
      if (i_csr_addr == `NTBWS_OFS_US_UPPER) begin
        us_upper_reg <= i_csr_wdata; // [R6] [R7]
      end
    end
  end

  // ----------------------------------------------------------------
  // Upstream setup and pointer
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      us_pf_reg   <= `NTBWS_RST_US_PF;
      us_mask_reg <= `NTBWS_RST_US_MASK; // [R9]
    end else if (i_csr_wr && i_csr_addr == `NTBWS_OFS_US_SETUP) begin
      us_pf_reg   <= i_csr_wdata[`NTBWS_PF_BIT]; // [R9]
      us_mask_reg <= i_csr_wdata[`NTBWS_US_MASK_HI:`NTBWS_MASK_LO];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ptr_reg <= `NTBWS_RST_PTR; // [R10]
    end else if (i_csr_wr && i_csr_addr == `NTBWS_OFS_PTR) begin
      ptr_reg <= i_csr_wdata[`NTBWS_PTR_HI:0]; // [R10]
    end
  end

  // ----------------------------------------------------------------
  // Lookup table
  // ----------------------------------------------------------------
  // Entries are words, so the two low pointer bits do not select.
  assign lut_wr = i_csr_wr && i_csr_addr == `NTBWS_OFS_LUT_DATA; // [R11] [R13]

  ntbws_lut u_lut (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_wr      (lut_wr),
    .i_idx     (ptr_reg[`NTBWS_LUT_IDX_HI:`NTBWS_LUT_IDX_LO]), // [R12]
    .i_wdata   (i_csr_wdata),
    .o_rdata   (lut_rdata)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (i_csr_addr)
      `NTBWS_OFS_DS_SETUP: rdata_next = ds_setup_reg; // [R1]
      `NTBWS_OFS_DS_UPPER: rdata_next = ds_upper_reg;
      `NTBWS_OFS_US_SETUP: rdata_next = {us_mask_reg, 8'h00, us_pf_reg,
                                         `NTBWS_WIDTH_64, 1'b0}; // [R1] [R8] [R9]
      `NTBWS_OFS_US_UPPER: rdata_next = us_upper_reg;
      `NTBWS_OFS_PTR:      rdata_next = {24'h00_0000, ptr_reg}; // [R10]
      `NTBWS_OFS_LUT_DATA: rdata_next = lut_rdata; // [R13]
      default:             rdata_next = 32'h0000_0000;
    endcase
  end

  // Unmapped offsets still answer, with zero, so a probe never hangs.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_csr_rdata <= 32'h0000_0000;
      o_csr_ack   <= 1'b0;
    end else begin
      o_csr_ack <= i_csr_wr | i_csr_rd;
      if (i_csr_rd) begin
        o_csr_rdata <= rdata_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Window outputs
  // ----------------------------------------------------------------
  assign o_ds_claim_en       = ds_setup_reg[`NTBWS_EN_BIT]; // [R5] [R14]
  assign o_ds_prefetch       = ds_setup_reg[`NTBWS_PF_BIT]; // [R3]
  assign o_ds_width          = ds_setup_reg[`NTBWS_WIDTH_HI:`NTBWS_WIDTH_LO]; // [R2]
  assign o_ds_base_rw_mask   = ds_setup_reg[`NTBWS_EN_BIT] ?
                               {1'b0, ds_setup_reg[`NTBWS_DS_MASK_HI:`NTBWS_MASK_LO],
                                12'h000} : 32'h0000_0000; // [R4] [R14]
  assign o_ds_upper_claim_en = ds_upper_reg[`NTBWS_EN_BIT]; // [R7]
  assign o_ds_upper_rw_mask  = ds_upper_reg[`NTBWS_EN_BIT] ?
                               {1'b0, ds_upper_reg[30:0]} : 32'h0000_0000; // [R6] [R14]
  assign o_us_prefetch       = us_pf_reg; // [R3]
  assign o_us_base_rw_mask   = {us_mask_reg, 12'h000}; // [R9]
  assign o_us_upper_claim_en = us_upper_reg[`NTBWS_EN_BIT]; // [R7]
  assign o_us_upper_rw_mask  = us_upper_reg[`NTBWS_EN_BIT] ?
                               {1'b0, us_upper_reg[30:0]} : 32'h0000_0000; // [R6] [R14]

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_lut_write;
    i_csr_wr && i_csr_addr == `NTBWS_OFS_LUT_DATA && !i_init_load_writable;
  endsequence

  sequence s_lut_read_next;
    ##1 (i_csr_rd && !i_csr_wr && i_csr_addr == `NTBWS_OFS_LUT_DATA);
  endsequence

  a_type_bit_zero: assert property (i_csr_rd && (i_csr_addr == `NTBWS_OFS_DS_SETUP ||
    i_csr_addr == `NTBWS_OFS_US_SETUP) |=> o_csr_rdata[0] == 1'b0) // [R1]
    else $error("setup type bit not zero");
  a_ds_width_code: assert property (i_init_load_writable |=>
    o_ds_width == $past(i_init_data[2:1])) // [R2]
    else $error("downstream width not loaded");
  a_ds_sw_locked: assert property (i_csr_wr && i_csr_addr == `NTBWS_OFS_DS_SETUP &&
    !i_init_load_writable |=> $stable(ds_setup_reg)) // [R3]
    else $error("downstream setup changed by software");
  a_ds_mask_gate: assert property (o_ds_base_rw_mask ==
    (o_ds_claim_en ? {1'b0, ds_setup_reg[30:12], 12'h000} : 32'h0)) // [R4]
    else $error("downstream base mask wrong");
  a_upper_write: assert property (i_csr_wr && i_csr_addr == `NTBWS_OFS_DS_UPPER |=>
    o_ds_upper_claim_en == $past(i_csr_wdata[31])) // [R7]
    else $error("upper enable not written");
  a_us_width_fixed: assert property (i_csr_rd && i_csr_addr == `NTBWS_OFS_US_SETUP |=>
    o_csr_rdata[2:1] == `NTBWS_WIDTH_64 && o_csr_rdata[11:4] == 8'h00) // [R8]
    else $error("upstream width or reserved field wrong");
  a_us_mask_write: assert property (i_csr_wr && i_csr_addr == `NTBWS_OFS_US_SETUP |=>
    o_us_base_rw_mask[31:12] == $past(i_csr_wdata[31:12])) // [R9]
    else $error("upstream mask not written");
  a_ptr_high_zero: assert property (i_csr_rd && i_csr_addr == `NTBWS_OFS_PTR |=>
    o_csr_rdata[31:8] == 24'h0 && o_csr_ack) // [R10]
    else $error("pointer upper bits not zero");
  a_lut_roundtrip: assert property (s_lut_write ##0 s_lut_read_next |=>
    o_csr_rdata == ($past(i_csr_wdata, 2) & `NTBWS_LUT_WMASK)) // [R13]
    else $error("lookup entry readback mismatch");
  a_disabled_quiet: assert property (!o_ds_claim_en |-> // [R14]
    o_ds_base_rw_mask == 32'h0000_0000)
    else $error("disabled window still open");
  a_upper_quiet: assert property (!o_us_upper_claim_en |-> // [R14]
    o_us_upper_rw_mask == 32'h0000_0000)
    else $error("disabled upper window still open");

endmodule : ntbws_regs

// ---- verif/ntbws_regs_tb_top.sv ----
`timescale 1ns/1ns
`include "ntbws_cfg.svh"

module ntbws_regs_tb_top
  import ntbws_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        i_ref_clk, i_rst, i_csr_wr, i_csr_rd, i_init_load_writable;
  logic        o_csr_ack, o_ds_claim_en, o_ds_prefetch, o_ds_upper_claim_en;
  logic        o_us_prefetch, o_us_upper_claim_en;
  logic [1:0]  o_ds_width;
  ntbws_addr_t i_csr_addr;
  ntbws_word_t i_csr_wdata, i_init_data, o_csr_rdata, o_ds_base_rw_mask;
  ntbws_word_t o_ds_upper_rw_mask, o_us_base_rw_mask, o_us_upper_rw_mask;
  ntbws_word_t exp_q[$], d, e, m;
  logic        chk_q[$];
  logic [7:0]  p1, p2;
  int          bad_count, cmp_count, cyc;

  ntbws_regs DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_csr_wr(i_csr_wr),
    .i_csr_rd(i_csr_rd), .i_csr_addr(i_csr_addr), .i_csr_wdata(i_csr_wdata),
    .o_csr_rdata(o_csr_rdata), .o_csr_ack(o_csr_ack),
    .i_init_load_writable(i_init_load_writable), .i_init_data(i_init_data),
    .o_ds_claim_en(o_ds_claim_en), .o_ds_prefetch(o_ds_prefetch), .o_ds_width(o_ds_width),
    .o_ds_base_rw_mask(o_ds_base_rw_mask), .o_ds_upper_claim_en(o_ds_upper_claim_en),
    .o_ds_upper_rw_mask(o_ds_upper_rw_mask), .o_us_prefetch(o_us_prefetch),
    .o_us_base_rw_mask(o_us_base_rw_mask), .o_us_upper_claim_en(o_us_upper_claim_en),
    .o_us_upper_rw_mask(o_us_upper_rw_mask));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string n, input ntbws_word_t ex, input ntbws_word_t s);
    cmp_count++;
    if (s !== ex) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, ex, s);
    end
  endtask : cmp

  task automatic csr(input logic wr, input ntbws_addr_t a, input ntbws_word_t dw,
                     input ntbws_word_t ex);
    @(negedge i_ref_clk);
    i_csr_wr = wr;
    i_csr_rd = !wr;
    i_csr_addr = a;
    i_csr_wdata = dw;
    exp_q.push_back(ex);
    chk_q.push_back(!wr);
    @(negedge i_ref_clk);
    i_csr_wr = 1'b0;
    i_csr_rd = 1'b0;
  endtask : csr

  // A data write followed at once by a read of the same entry, with no idle cycle.
  task automatic lut_b2b(input ntbws_word_t dw);
    @(negedge i_ref_clk);
    i_csr_wr = 1'b1;
    i_csr_addr = `NTBWS_OFS_LUT_DATA;
    i_csr_wdata = dw;
    exp_q.push_back(32'h0);
    chk_q.push_back(1'b0);
    @(negedge i_ref_clk);
    i_csr_wr = 1'b0;
    i_csr_rd = 1'b1;
    exp_q.push_back(dw & 32'hffff_ff09);
    chk_q.push_back(1'b1);
    @(negedge i_ref_clk);
    i_csr_rd = 1'b0;
  endtask : lut_b2b

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Clock, watchdog and read-data monitor
  // ----------------------------------------------------------------
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  // The whole run is about 120 cycles, so this ceiling only trips on a hang.
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      stop_test();
    end
  end

  always @(negedge i_ref_clk) begin
    if (o_csr_ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp("unexpected ack", 32'h0, 32'h1);
      end else begin
        m = exp_q.pop_front();
        if (chk_q.pop_front()) cmp("read data", m, o_csr_rdata);
      end
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    i_rst = 1'b1;
    i_csr_wr = 1'b0;
    i_csr_rd = 1'b0;
    i_csr_addr = 8'h00;
    i_csr_wdata = 32'h0;
    i_init_load_writable = 1'b0;
    i_init_data = 32'h0;
    void'($urandom(52464));
    repeat (12) @(negedge i_ref_clk);
    i_rst = 1'b0;
    csr(0, `NTBWS_OFS_DS_SETUP, 0, 32'h0);
    csr(0, `NTBWS_OFS_DS_UPPER, 0, 32'h0);
    csr(0, `NTBWS_OFS_US_SETUP, 0, 32'h2);
    csr(0, `NTBWS_OFS_US_UPPER, 0, 32'h0);
    csr(0, `NTBWS_OFS_PTR, 0, 32'h0);
    cmp("ds claim", 32'h0, {31'h0, o_ds_claim_en});
    csr(1, `NTBWS_OFS_DS_SETUP, 32'hffff_ffff, 0);
    csr(0, `NTBWS_OFS_DS_SETUP, 0, 32'h0);
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      d[31] = i[1];
      d[2:1] = {1'b0, i[0]};
      @(negedge i_ref_clk);
      i_init_load_writable = 1'b1;
      i_init_data = d;
      @(negedge i_ref_clk);
      i_init_load_writable = 1'b0;
      csr(0, `NTBWS_OFS_DS_SETUP, 0, d & 32'hffff_f00e);
      cmp("ds width", {30'h0, d[2:1]}, {30'h0, o_ds_width});
      cmp("ds prefetch", {31'h0, d[3]}, {31'h0, o_ds_prefetch});
      cmp("ds claim", {31'h0, d[31]}, {31'h0, o_ds_claim_en});
      cmp("ds mask", d[31] ? {1'b0, d[30:12], 12'h0} : 32'h0, o_ds_base_rw_mask);
    end
    for (int j = 0; j < 4; j++) begin
      d = $urandom;
      d[31] = j[0];
      csr(1, j[1] ? `NTBWS_OFS_US_UPPER : `NTBWS_OFS_DS_UPPER, d, 0);
      csr(0, j[1] ? `NTBWS_OFS_US_UPPER : `NTBWS_OFS_DS_UPPER, 0, d);
      cmp("upper claim", {31'h0, d[31]},
          {31'h0, j[1] ? o_us_upper_claim_en : o_ds_upper_claim_en});
      cmp("upper mask", d[31] ? {1'b0, d[30:0]} : 32'h0,
          j[1] ? o_us_upper_rw_mask : o_ds_upper_rw_mask);
    end
    csr(1, `NTBWS_OFS_US_SETUP, 32'hffff_ffff, 0);
    csr(0, `NTBWS_OFS_US_SETUP, 0, 32'hffff_f00a);
    cmp("us prefetch", 32'h1, {31'h0, o_us_prefetch});
    cmp("us mask", 32'hffff_f000, o_us_base_rw_mask);
    csr(1, `NTBWS_OFS_US_SETUP, 32'h0, 0);
    csr(0, `NTBWS_OFS_US_SETUP, 0, 32'h2);
    csr(1, `NTBWS_OFS_PTR, 32'hffff_ffff, 0);
    csr(0, `NTBWS_OFS_PTR, 0, 32'hff);
    p1 = {6'($urandom_range(63, 0)), 2'b00};
    p2 = p1 ^ 8'h04;
    d = $urandom;
    e = $urandom;
    csr(1, `NTBWS_OFS_PTR, {24'h0, p1}, 0);
    csr(1, `NTBWS_OFS_LUT_DATA, d, 0);
    csr(1, `NTBWS_OFS_PTR, {24'h0, p2}, 0);
    csr(1, `NTBWS_OFS_LUT_DATA, e, 0);
    csr(1, `NTBWS_OFS_PTR, {24'h0, p1}, 0);
    csr(0, `NTBWS_OFS_LUT_DATA, 0, d & 32'hffff_ff09);
    csr(0, `NTBWS_OFS_PTR, 0, {24'h0, p1});
    csr(1, `NTBWS_OFS_PTR, {24'h0, p2}, 0);
    csr(0, `NTBWS_OFS_LUT_DATA, 0, e & 32'hffff_ff09);
    csr(1, 8'h20, 32'hffff_ffff, 0);
    csr(0, 8'h20, 0, 32'h0);
    csr(0, `NTBWS_OFS_PTR, 0, {24'h0, p2});
    lut_b2b($urandom);
    repeat (2) @(negedge i_ref_clk);
    i_rst = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    i_rst = 1'b0;
    cmp("ds claim", 32'h0, {31'h0, o_ds_claim_en});
    csr(0, `NTBWS_OFS_US_SETUP, 0, 32'h2);
    csr(0, `NTBWS_OFS_PTR, 0, 32'h0);
    csr(0, `NTBWS_OFS_US_UPPER, 0, 32'h0);
    csr(0, `NTBWS_OFS_DS_SETUP, 0, 32'h0);
    csr(0, `NTBWS_OFS_LUT_DATA, 0, 32'h0);
    repeat (4) @(negedge i_ref_clk);
    cmp("pending reads", 32'h0, exp_q.size());
    stop_test();
  end
endmodule : ntbws_regs_tb_top
